// ===== src/pda_addr.sv
// program counter, return stack, page registers and memory address forming
`default_nettype none
`include "pda_map.svh"
module pda_addr
   import pda_pkg::*;
#(
   parameter int DEPTH = `PDA_STACK_DEPTH
) (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire pda_op_e     pc_op,
   input  wire logic [12:0] target,
   input  wire logic [4:0]  irq_req,
   input  wire logic        reg_wr,
   input  wire logic [1:0]  reg_sel,
   input  wire logic [3:0]  reg_wdata,
   input  wire logic        tab_wr,
   input  wire logic [1:0]  tab_sel,
   input  wire logic [3:0]  tab_wdata,
   input  wire pda_da_e     da_mode,
   input  wire logic [6:0]  da_offset,
   input  wire logic        imm_op,
   input  wire logic [15:0] rom_word,
   output logic [12:0]      pc,
   output logic [14:0]      lut_addr,
   output logic [3:0]       lut_data,
   output logic [9:0]       dmem_addr,
   output logic             imm_illegal,
   output logic [3:0]       reg_rdata,
   output logic [2:0]       stack_ptr,
   output logic [12:0]      rom_addr
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   pda_state_s st_r;
   pda_state_s st_nxt;
   logic       irq_any;
   logic [12:0] vec;
   logic [2:0]  sp_up;
   logic [2:0]  sp_dn;

   // ----------------------------------------------------------------
   // interrupt vector
   // ----------------------------------------------------------------
   always_comb begin
      irq_any = |irq_req;
      if (irq_req[0]) begin
         vec = `PDA_VEC_DIV0;
      end else if (irq_req[1]) begin
         vec = `PDA_VEC_TMR0;
      end else if (irq_req[2]) begin
         vec = `PDA_VEC_PORT;
      end else if (irq_req[3]) begin
         vec = `PDA_VEC_DIV1;
      end else if (irq_req[4]) begin
         vec = `PDA_VEC_TMR1;
      end else begin
         vec = `PDA_RESET_VEC;
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      sp_up  = st_r.sp + 3'h1;
      sp_dn  = st_r.sp - 3'h1;
      if (irq_any) begin
         // interrupt entry saves the current pc, not pc + 1 as a call does
         st_nxt.stk[st_r.sp] = st_r.pc;
         st_nxt.sp = sp_up;
         st_nxt.pc = vec;
      end else begin
         case (pc_op)
            PDA_OP_NEXT: begin
               st_nxt.pc = st_r.pc + 13'h0001;
            end
            PDA_OP_JUMP: begin
               st_nxt.pc = {st_r.prog_page[1:0], target[10:0]};
            end
            PDA_OP_CALL: begin
               st_nxt.stk[st_r.sp] = st_r.pc + 13'h0001;
               st_nxt.sp = sp_up;
               st_nxt.pc = {st_r.prog_page[1:0], target[10:0]};
            end
            PDA_OP_RET: begin
               st_nxt.pc = st_r.stk[sp_dn];
               st_nxt.sp = sp_dn;
            end
            PDA_OP_BRCH: begin
               st_nxt.pc = {st_r.pc[12:11], target[10:0]};
            end
            default: begin
               st_nxt.pc = st_r.pc;
            end
         endcase
      end
      if (reg_wr) begin
         if (reg_sel == `PDA_SEL_PROG) begin
            st_nxt.prog_page = {2'h0, reg_wdata[1:0]};
         end else if (reg_sel == `PDA_SEL_IND) begin
            st_nxt.ind_page = {1'h0, reg_wdata[2:0]};
         end else if (reg_sel == `PDA_SEL_WRP) begin
            st_nxt.work_reg_page_select = reg_wdata;
         end else begin
            st_nxt.bank = {1'h0, reg_wdata[2:0]};
         end
      end
      if (tab_wr) begin
         st_nxt.tab[tab_sel*4 +: 4] = tab_wdata;
      end
      st_nxt.lut_addr = st_r.tab[14:0];
      // nibble 0 of a word is its low nibble
      st_nxt.rd_data = rom_word[st_r.lut_addr[1:0]*4 +: 4];
      case (da_mode)
         PDA_DA_INDIR: begin
            st_nxt.dmem_addr = {st_r.bank[2:0], st_r.ind_page[2:0], da_offset[3:0]};
         end
         PDA_DA_WORK: begin
            st_nxt.dmem_addr = {2'h0, st_r.work_reg_page_select, da_offset[3:0]};
         end
         default: begin
            st_nxt.dmem_addr = {st_r.bank[2:0], da_offset};
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_r    <= '0;
         st_r.pc <= `PDA_RESET_VEC;
         st_r.prog_page <= `PDA_REG_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   always_comb begin
      pc          = st_r.pc;
      rom_addr    = (pc_op == PDA_OP_HOLD) ? {st_r.lut_addr[14:2]} : st_r.pc;
      lut_addr    = st_r.lut_addr;
      lut_data    = st_r.rd_data;
      dmem_addr   = st_r.dmem_addr;
      stack_ptr   = st_r.sp;
      imm_illegal = imm_op && (da_mode != PDA_DA_WORK);
      if (reg_sel == `PDA_SEL_PROG) begin
         reg_rdata = st_r.prog_page;
      end else if (reg_sel == `PDA_SEL_IND) begin
         reg_rdata = st_r.ind_page;
      end else if (reg_sel == `PDA_SEL_WRP) begin
         reg_rdata = st_r.work_reg_page_select;
      end else begin
         reg_rdata = st_r.bank;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence call_s;
      !irq_any && pc_op == PDA_OP_CALL;
   endsequence
   sequence ret_s;
      !irq_any && pc_op == PDA_OP_RET;
   endsequence

   reset_vector_a: assert property (@(posedge mclk) !rst_n |=> pc == 13'h0000)
      else $error("pc not at reset vector");
   irq_vector_a: assert property (@(posedge mclk) disable iff (!rst_n)
      irq_req[0] |=> pc == 13'h0004)
      else $error("divider vector wrong");
   irq_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
      irq_req == 5'h10 |=> pc == 13'h0020)
      else $error("timer vector wrong");
   call_return_a: assert property (@(posedge mclk) disable iff (!rst_n)
      call_s ##1 ret_s |=> pc == $past(pc, 2) + 13'h0001)
      else $error("return address mismatch");
   call_page_a: assert property (@(posedge mclk) disable iff (!rst_n)
      call_s |=> pc[12:11] == $past(st_r.prog_page[1:0]))
      else $error("call page wrong");
   branch_page_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (!irq_any && pc_op == PDA_OP_BRCH) |=> pc[12:11] == $past(pc[12:11]))
      else $error("branch left page");
   sp_wrap_a: assert property (@(posedge mclk) disable iff (!rst_n)
      call_s |=> stack_ptr == $past(stack_ptr) + 3'h1)
      else $error("stack pointer step wrong");
   work_addr_a: assert property (@(posedge mclk) disable iff (!rst_n)
      da_mode == PDA_DA_WORK |=> dmem_addr[9:8] == 2'h0)
      else $error("working register outside first banks");
   imm_check_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (imm_op && da_mode == PDA_DA_DIRECT) |-> imm_illegal)
      else $error("immediate on data memory not flagged");
   page_rsvd_a: assert property (@(posedge mclk) disable iff (!rst_n)
      st_r.prog_page[3:2] == 2'h0 && st_r.ind_page[3] == 1'h0)
      else $error("reserved page bits set");

   // ----------------------------------------------------------------
   // sequencing checks
   // ----------------------------------------------------------------
   // each step is one cycle, so the checks look one edge ahead only
   sequence next_s;
      !irq_any && pc_op == PDA_OP_NEXT;
   endsequence
   sequence jump_s;
      !irq_any && pc_op == PDA_OP_JUMP;
   endsequence
   sequence brch_s;
      !irq_any && pc_op == PDA_OP_BRCH;
   endsequence
   sequence hold_s;
      !irq_any && pc_op == PDA_OP_HOLD;
   endsequence

   reset_sp_a: assert property (@(posedge mclk) !rst_n |=> stack_ptr == 3'h0)
      else $error("stack pointer not cleared by reset");
   next_inc_a: assert property (@(posedge mclk) disable iff (!rst_n)
      next_s |=> pc == $past(pc) + 13'h0001)
      else $error("counter did not advance");
   hold_pc_a: assert property (@(posedge mclk) disable iff (!rst_n)
      hold_s |=> pc == $past(pc))
      else $error("counter moved while held");
   jump_page_a: assert property (@(posedge mclk) disable iff (!rst_n)
      jump_s |=> pc == {$past(st_r.prog_page[1:0]), $past(target[10:0])})
      else $error("jump target wrong");
   jump_sp_a: assert property (@(posedge mclk) disable iff (!rst_n)
      jump_s |=> stack_ptr == $past(stack_ptr))
      else $error("jump touched the stack");
   branch_sp_a: assert property (@(posedge mclk) disable iff (!rst_n)
      brch_s |=> stack_ptr == $past(stack_ptr))
      else $error("branch touched the stack");
   branch_tgt_a: assert property (@(posedge mclk) disable iff (!rst_n)
      brch_s |=> pc[10:0] == $past(target[10:0]))
      else $error("branch offset wrong");

   // ----------------------------------------------------------------
   // interrupt and stack checks
   // ----------------------------------------------------------------
   irq_tmr0_a: assert property (@(posedge mclk) disable iff (!rst_n)
      irq_req[1:0] == 2'h2 |=> pc == 13'h0008)
      else $error("second vector wrong");
   irq_port_a: assert property (@(posedge mclk) disable iff (!rst_n)
      irq_req[2:0] == 3'h4 |=> pc == 13'h000C)
      else $error("port vector wrong");
   irq_div1_a: assert property (@(posedge mclk) disable iff (!rst_n)
      irq_req[3:0] == 4'h8 |=> pc == 13'h0014)
      else $error("fourth vector wrong");
   irq_push_a: assert property (@(posedge mclk) disable iff (!rst_n)
      irq_any |=> st_r.stk[$past(st_r.sp)] == $past(pc))
      else $error("interrupt did not save counter");
   irq_sp_a: assert property (@(posedge mclk) disable iff (!rst_n)
      irq_any |=> stack_ptr == $past(stack_ptr) + 3'h1)
      else $error("interrupt stack step wrong");
   call_push_a: assert property (@(posedge mclk) disable iff (!rst_n)
      call_s |=> st_r.stk[$past(st_r.sp)] == $past(pc) + 13'h0001)
      else $error("call saved wrong address");
   ret_pop_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ret_s |=> pc == $past(st_r.stk[sp_dn]))
      else $error("return popped wrong entry");
   ret_sp_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ret_s |=> stack_ptr == $past(stack_ptr) - 3'h1)
      else $error("return stack step wrong");

   // ----------------------------------------------------------------
   // register and table checks
   // ----------------------------------------------------------------
   bank_rsvd_a: assert property (@(posedge mclk) disable iff (!rst_n)
      st_r.bank[3] == 1'h0)
      else $error("reserved bank bit set");
   wr_prog_a: assert property (@(posedge mclk) disable iff (!rst_n)
      reg_wr && reg_sel == `PDA_SEL_PROG |=>
      st_r.prog_page == {2'h0, $past(reg_wdata[1:0])})
      else $error("program page write lost");
   wr_bank_a: assert property (@(posedge mclk) disable iff (!rst_n)
      reg_wr && reg_sel == `PDA_SEL_BANK |=>
      st_r.bank == {1'h0, $past(reg_wdata[2:0])})
      else $error("bank write lost");
   rd_work_a: assert property (@(posedge mclk) disable iff (!rst_n)
      reg_sel == `PDA_SEL_WRP |-> reg_rdata == st_r.work_reg_page_select)
      else $error("working page readback wrong");
   tab_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
      tab_wr && tab_sel == 2'h0 |=> st_r.tab[3:0] == $past(tab_wdata))
      else $error("low table nibble not loaded");
   lut_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
      1'b1 |=> lut_addr == $past(st_r.tab[14:0]))
      else $error("table address does not follow pointer");
   hold_rom_a: assert property (@(posedge mclk) disable iff (!rst_n)
      pc_op == PDA_OP_HOLD |-> rom_addr == st_r.lut_addr[14:2])
      else $error("table word not fetched");

   // ----------------------------------------------------------------
   // data address checks
   // ----------------------------------------------------------------
   dir_addr_a: assert property (@(posedge mclk) disable iff (!rst_n)
      da_mode == PDA_DA_DIRECT |=>
      dmem_addr == {$past(st_r.bank[2:0]), $past(da_offset)})
      else $error("direct address wrong");
   ind_addr_a: assert property (@(posedge mclk) disable iff (!rst_n)
      da_mode == PDA_DA_INDIR |=> dmem_addr[6:4] == $past(st_r.ind_page[2:0]))
      else $error("indirect page wrong");
   ind_bank_a: assert property (@(posedge mclk) disable iff (!rst_n)
      da_mode == PDA_DA_INDIR |=> dmem_addr[9:7] == $past(st_r.bank[2:0]))
      else $error("indirect bank wrong");
   work_page_a: assert property (@(posedge mclk) disable iff (!rst_n)
      da_mode == PDA_DA_WORK |=> dmem_addr[7:4] == $past(st_r.work_reg_page_select))
      else $error("working page wrong");
   imm_work_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (imm_op && da_mode == PDA_DA_WORK) |-> !imm_illegal)
      else $error("immediate on working register flagged");
endmodule
`default_nettype wire

// ===== src/pda_map.svh
// constants for the program and data addressing block
`ifndef PDA_MAP_SVH
`define PDA_MAP_SVH
`define PDA_PC_W        13
`define PDA_RESET_VEC   13'h0000
`define PDA_VEC_DIV0    13'h0004
`define PDA_VEC_TMR0    13'h0008
`define PDA_VEC_PORT    13'h000C
`define PDA_VEC_DIV1    13'h0014
`define PDA_VEC_TMR1    13'h0020
`define PDA_STACK_DEPTH 8
`define PDA_PAGE_OFS_W  11
`define PDA_ROM_PAGE_LO 0
`define PDA_ROM_PAGE_HI 1
`define PDA_IND_PAGE_HI 2
`define PDA_BANK_HI     2
`define PDA_REG_RESET   4'h0
`define PDA_SEL_PROG    2'h0
`define PDA_SEL_IND     2'h1
`define PDA_SEL_WRP     2'h2
`define PDA_SEL_BANK    2'h3
`endif

// ===== src/pda_pkg.sv
// types of the program and data addressing block
`default_nettype none
package pda_pkg;
   typedef enum logic [2:0] {
      PDA_OP_NEXT = 3'h0,
      PDA_OP_JUMP = 3'h1,
      PDA_OP_CALL = 3'h3,
      PDA_OP_RET  = 3'h2,
      PDA_OP_BRCH = 3'h6,
      PDA_OP_HOLD = 3'h7
   } pda_op_e;
   typedef enum logic [1:0] {
      PDA_DA_DIRECT = 2'h0,
      PDA_DA_INDIR  = 2'h1,
      PDA_DA_WORK   = 2'h3
   } pda_da_e;
   typedef struct packed {
      logic [12:0]      pc;
      logic [7:0][12:0] stk;
      logic [2:0]       sp;
      logic [3:0]       prog_page;
      logic [3:0]       ind_page;
      logic [3:0]       work_reg_page_select;
      logic [3:0]       bank;
      logic [15:0]      tab;
      logic [9:0]       dmem_addr;
      logic [14:0]      lut_addr;
      logic [3:0]       rd_data;
   } pda_state_s;
endpackage
`default_nettype wire

// ===== tb/pda_rom_model.sv
// program store model standing behind the addressing block
`default_nettype none
module pda_rom_model (
   input  wire logic [12:0] rom_addr,
   output logic      [15:0] rom_word
);
   timeunit 1ns;
   timeprecision 1ps;
   // every address bit moves the word, so a wrong fetch address shows
   assign rom_word = {rom_addr[11:0], rom_addr[12:9]} ^ 16'h5A3C;
endmodule
`default_nettype wire

// ===== tb/program_and_data_addressing_test.sv
// self-checking bench for the program and data addressing block
`default_nettype none
`include "pda_map.svh"
module program_and_data_addressing_test
   import pda_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic        mclk      = 1'b0;
   logic        rst_n     = 1'b0;
   pda_op_e     pc_op     = PDA_OP_HOLD;
   logic [12:0] target    = 13'h0000;
   logic [4:0]  irq_req   = 5'h00;
   logic        reg_wr    = 1'b0;
   logic [1:0]  reg_sel   = 2'h0;
   logic [3:0]  reg_wdata = 4'h0;
   logic        tab_wr    = 1'b0;
   logic [1:0]  tab_sel   = 2'h0;
   logic [3:0]  tab_wdata = 4'h0;
   pda_da_e     da_mode   = PDA_DA_DIRECT;
   logic [6:0]  da_offset = 7'h00;
   logic        imm_op    = 1'b0;
   logic [15:0] rom_word;
   logic [12:0] pc;
   logic [14:0] lut_addr;
   logic [3:0]  lut_data;
   logic [9:0]  dmem_addr;
   logic        imm_illegal;
   logic [3:0]  reg_rdata;
   logic [2:0]  stack_ptr;
   logic [12:0] rom_addr;
   logic [14:0] la;
   logic [15:0] w;
   int          bad_count = 0;
   int          checks    = 0;
   int          cyc       = 0;
   logic [3:0]  msk [4] = '{4'h3, 4'h7, 4'hF, 4'h7};
   logic [12:0] vec [5] = '{`PDA_VEC_DIV0, `PDA_VEC_TMR0, `PDA_VEC_PORT,
                            `PDA_VEC_DIV1, `PDA_VEC_TMR1};
   pda_da_e     mds [3] = '{PDA_DA_DIRECT, PDA_DA_INDIR, PDA_DA_WORK};
   logic [9:0]  dex [3] = '{10'h2AB, 10'h2BB, 10'h0AB};
   always #5 mclk = ~mclk;
   pda_addr i_dut (.mclk(mclk), .rst_n(rst_n), .pc_op(pc_op), .target(target),
      .irq_req(irq_req), .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
      .tab_wr(tab_wr), .tab_sel(tab_sel), .tab_wdata(tab_wdata), .da_mode(da_mode),
      .da_offset(da_offset), .imm_op(imm_op), .rom_word(rom_word), .pc(pc),
      .lut_addr(lut_addr), .lut_data(lut_data), .dmem_addr(dmem_addr),
      .imm_illegal(imm_illegal), .reg_rdata(reg_rdata), .stack_ptr(stack_ptr),
      .rom_addr(rom_addr));
   pda_rom_model i_rom (.rom_addr(rom_addr), .rom_word(rom_word));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   function automatic logic [15:0] rom_f(input logic [12:0] a);
      return {a[11:0], a[12:9]} ^ 16'h5A3C;
   endfunction
   task automatic tick();
      @(posedge mclk);
      #1;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [1:0] s, input logic [3:0] v);
      reg_wr = 1'b1;
      reg_sel = s;
      reg_wdata = v;
      tick();
      reg_wr = 1'b0;
      tick();
   endtask
   task automatic wr_tab(input logic [1:0] s, input logic [3:0] v);
      tab_wr = 1'b1;
      tab_sel = s;
      tab_wdata = v;
      tick();
      tab_wr = 1'b0;
      tick();
   endtask
   task automatic step(input pda_op_e op, input logic [12:0] t);
      pc_op = op;
      target = t;
      tick();
   endtask
   task automatic test_done();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // hang guard: the sequence needs a few hundred cycles at most
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         bad_count++;
         test_done();
      end
   end
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      repeat (16) tick();
      rst_n = 1'b1;
      chk(16'(pc), 16'(`PDA_RESET_VEC));
      for (int i = 0; i < 4; i++) begin
         reg_sel = 2'(i);
         #1;
         chk(16'(reg_rdata), 16'h0000);
         wr_reg(2'(i), 4'hF);
         chk(16'(reg_rdata), 16'(msk[i]));
      end
      wr_reg(2'h0, 4'h2);
      step(PDA_OP_JUMP, 13'h1ABC);
      chk(16'(pc), 16'h12BC);
      pc_op = PDA_OP_HOLD;
      wr_reg(2'h0, 4'h1);
      step(PDA_OP_BRCH, 13'h0155);
      chk(16'(pc), 16'h1155);
      pc_op = PDA_OP_HOLD;
      wr_reg(2'h0, 4'h0);
      // nine calls: the first return address falls off the bottom
      for (int i = 0; i < 9; i++) begin
         step(PDA_OP_CALL, 13'(13'h0100 + i));
         chk(16'(pc), 16'(13'h0100 + i));
         chk(16'(stack_ptr), 16'((i + 1) % 8));
      end
      for (int j = 8; j > 0; j--) begin
         step(PDA_OP_RET, 13'h0000);
         chk(16'(pc), 16'(13'h0100 + j));
      end
      pc_op = PDA_OP_HOLD;
      for (int i = 0; i < 5; i++) begin
         irq_req = 5'(5'h1F << i);
         tick();
         irq_req = 5'h00;
         chk(16'(pc), 16'(vec[i]));
         chk(16'(stack_ptr), 16'h0002);
         step(PDA_OP_RET, 13'h0000);
         chk(16'(pc), 16'h0101);
      end
      pc_op = PDA_OP_HOLD;
      wr_tab(2'h3, 4'h9);
      wr_tab(2'h2, 4'hA);
      wr_tab(2'h1, 4'h5);
      for (int k = 0; k < 4; k++) begin
         wr_tab(2'h0, 4'(4 + k));
         tick();
         tick();
         la = 15'h1A54 + 15'(k);
         w = rom_f(la[14:2]);
         chk(16'(lut_addr), 16'(la));
         chk(16'(lut_data), 16'(w[4*k +: 4]));
      end
      wr_reg(2'h3, 4'h5);
      wr_reg(2'h1, 4'h3);
      wr_reg(2'h2, 4'hA);
      da_offset = 7'h2B;
      imm_op = 1'b1;
      for (int m = 0; m < 3; m++) begin
         da_mode = mds[m];
         tick();
         chk(16'(dmem_addr), 16'(dex[m]));
         chk(16'(imm_illegal), 16'(m != 2));
      end
      test_done();
   end
endmodule
`default_nettype wire
